/* hdl/brightness_limit_monitor.sv */
// What this block does
// - One to three channels, each with own output
// - Limit is either upper or lower threshold
// - Upper limit: lower is limit minus 1..20%
// - Lower limit: upper is limit plus 1..20%
// - Limit lies within 10..2000 lux, default 1000
// - Download overwrites external value only if allowed
// - Without external value the configured limit applies
// - Bus float preset becomes the new limit
// - External limit holds until next preset/teach/overwrite
// - Teach captures measured brightness as limit
// - Teach polarity; opposite value restores configured limit
// - Feedback sent on change, download, bus return
// - Output as switch, dim value or scene
// - Rise and fall telegrams enabled separately
// - Channels compared continuously and independently
// - Disabled evaluation sends no telegrams, presets and feedback still work
//
// Purpose: Brightness limit monitor with Avalon-MM register access
// Assumes: Brightness is written by software in whole lux
// Notes:   Telegrams and feedback leave as one-cycle pulses, one per cycle each
`timescale 1ns/1ps
`default_nettype none
module brightness_limit_monitor #(
    parameter logic [15:0] MS_TICK_CYCLES = limit_pkg::MS_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic [7:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    output logic [31:0]                readdata,
    output logic                       waitrequest,
    input  wire logic                  bus_return,
    input  wire logic                  cfg_download,
    output logic                       irq,
    output var  limit_pkg::telegram_t  tel,
    output var  limit_pkg::feedback_t  fb
);
    import limit_pkg::*;

    typedef struct packed {
        ctrl_t                 ctrl;
        irq_t                  status;
        irq_t                  mask;
        logic [15:0]           bright;
        logic [7:0]            fb_delay;
        ch_cfg_t [NCH-1:0]     cfg;
        logic [NCH-1:0][15:0]  lim_cfg;
        logic [NCH-1:0][15:0]  tel_val;
        logic [NCH-1:0]        pend_up;
        logic [NCH-1:0]        pend_dn;
        logic [NCH-1:0]        pend_fb;
        logic [7:0]            dly_ms;
        logic [15:0]           div;
        logic [NCH-1:0]        preset;
        logic [NCH-1:0]        teach;
        logic                  teach_val;
        logic [15:0]           preset_val;
        logic                  wait_req;
        logic [31:0]           rdata;
        logic                  irq;
        telegram_t             tel;
        feedback_t             fb;
    } mon_state_t;

    mon_state_t           s;
    mon_state_t           n;
    logic [NCH-1:0][15:0] limit;
    thresh_t [NCH-1:0]    thr;
    logic [NCH-1:0]       up_evt;
    logic [NCH-1:0]       dn_evt;
    logic [NCH-1:0]       changed;
    logic [NCH-1:0]       cfgd;
    logic [NCH-1:0]       act;
    logic [1:0]           cnt;
    logic                 init;
    logic [2:0]           page;
    logic [4:0]           sub;
    logic [1:0]           ci;
    logic                 ch_ok;

    // A count of zero is read as one channel so the block never goes silent by accident
    assign cnt   = (s.ctrl.count == 2'h0) ? 2'h1 : s.ctrl.count;
    assign init  = bus_return || cfg_download;
    assign page  = address[7:5];
    assign sub   = address[4:0];
    assign ch_ok = (page >= PAGE_FIRST) && (page <= PAGE_LAST);
    assign ci    = 2'(page - PAGE_FIRST);

    // Per-channel limit keeping, thresholds and crossing detection
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign cfgd[g] = s.ctrl.enable && (2'(g) < cnt);
        assign act[g]  = cfgd[g] && !s.ctrl.eval_dis;

        threshold_calc u_thr (
            .ref_clk    (ref_clk),
            .rstn       (rstn),
            .limit      (limit[g]),
            .hyst       (s.cfg[g].hyst),
            .upper_type (s.cfg[g].upper_type),
            .thr        (thr[g])
        );

        limit_channel u_ch (
            .ref_clk    (ref_clk),
            .rstn       (rstn),
            .cfg        (s.cfg[g]),
            .cfg_limit  (s.lim_cfg[g]),
            .bright     (s.bright),
            .thr        (thr[g]),
            .preset     (s.preset[g]),
            .preset_val (s.preset_val),
            .teach      (s.teach[g]),
            .teach_val  (s.teach_val),
            .download   (cfg_download),
            .restart    (init),
            .eval_on    (act[g]),
            .limit      (limit[g]),
            .up_evt     (up_evt[g]),
            .dn_evt     (dn_evt[g]),
            .changed    (changed[g])
        );
    end

    // Whole next state: bus slave, pending telegrams, feedback and interrupt
    always_comb begin
        logic       tel_done;
        logic       fb_done;
        logic       up;
        logic [7:0] val;
        logic       tick;
        tel_done = 1'b0;
        fb_done  = 1'b0;
        up       = 1'b0;
        val      = '0;
        tick     = s.div == (MS_TICK_CYCLES - 16'h0001);
        n          = s;
        n.preset   = '0;
        n.teach    = '0;
        n.wait_req = 1'b1;
        n.tel      = '0;
        n.fb       = '0;

        // Answer comes one cycle after the request is seen
        if ((read || write) && s.wait_req) begin
            n.wait_req = 1'b0;
            n.rdata    = '0;
            if (read && page == PAGE_GLOBAL) begin
                case (address)
                    CTRL_OFS:   n.rdata = 32'(s.ctrl);
                    STATUS_OFS: n.rdata = 32'(s.status);
                    MASK_OFS:   n.rdata = 32'(s.mask);
                    BRIGHT_OFS: n.rdata = 32'(s.bright);
                    FBDLY_OFS:  n.rdata = 32'(s.fb_delay);
                    default:    n.rdata = '0;
                endcase
            end else if (read && ch_ok) begin
                case (sub)
                    SUB_CFG:   n.rdata = 32'(s.cfg[ci]);
                    SUB_LIMIT: n.rdata = 32'(s.lim_cfg[ci]);
                    SUB_TEL:   n.rdata = 32'(s.tel_val[ci]);
                    SUB_EFF:   n.rdata = 32'(limit[ci]);
                    SUB_THR:   n.rdata = 32'(thr[ci]);
                    default:   n.rdata = '0;
                endcase
            end
        end

        // Writes act on the edge that shows waitrequest low
        if (write && !s.wait_req) begin
            if (page == PAGE_GLOBAL) begin
                case (address)
                    CTRL_OFS:   n.ctrl = ctrl_t'(writedata[CTRL_W-1:0]);
                    STATUS_OFS: n.status = irq_t'(s.status & ~writedata[IRQ_W-1:0]);
                    MASK_OFS:   n.mask = irq_t'(writedata[IRQ_W-1:0]);
                    BRIGHT_OFS: n.bright = writedata[15:0];
                    FBDLY_OFS:  n.fb_delay = writedata[7:0];
                    default:    n.ctrl = s.ctrl;
                endcase
            end else if (ch_ok) begin
                case (sub)
                    SUB_CFG:   n.cfg[ci] = ch_cfg_t'(writedata[CFG_W-1:0]);
                    SUB_LIMIT: n.lim_cfg[ci] = writedata[15:0];
                    SUB_TEL:   n.tel_val[ci] = writedata[15:0];
                    SUB_PRESET: begin
                        n.preset[ci] = 1'b1;
                        n.preset_val = writedata[15:0];
                    end
                    SUB_TEACH: begin
                        n.teach[ci] = 1'b1;
                        n.teach_val = writedata[0];
                    end
                    default:   n.ctrl = s.ctrl;
                endcase
            end
        end

        // Millisecond divider paces the start-up feedback delay
        n.div = tick ? 16'h0000 : s.div + 16'h0001;
        if (init) begin
            n.dly_ms = s.fb_delay;
        end else if (tick && s.dly_ms != 8'h00) begin
            n.dly_ms = s.dly_ms - 8'h01;
        end

        // One crossing telegram per cycle, lowest channel first, rise before fall
        for (int i = 0; i < NCH; i++) begin
            if (!tel_done && act[i] && (s.pend_up[i] || s.pend_dn[i])) begin
                tel_done    = 1'b1;
                up          = s.pend_up[i];
                val         = up ? s.tel_val[i][7:0] : s.tel_val[i][15:8];
                n.tel.valid = 1'b1;
                n.tel.chan  = 2'(i);
                n.tel.fmt   = s.cfg[i].fmt;
                n.tel.data  = tel_data(s.cfg[i].fmt, val);
                if (up) begin
                    n.pend_up[i]   = 1'b0;
                    n.status.up[i] = 1'b1;
                end else begin
                    n.pend_dn[i]   = 1'b0;
                    n.status.dn[i] = 1'b1;
                end
            end
        end

        // Feedback waits out the delay that follows a download or bus return
        for (int i = 0; i < NCH; i++) begin
            if (!fb_done && s.dly_ms == 8'h00 && s.pend_fb[i]) begin
                fb_done        = 1'b1;
                n.fb.valid     = 1'b1;
                n.fb.chan      = 2'(i);
                n.fb.value     = lux_to_f16(limit[i]);
                n.pend_fb[i]   = 1'b0;
                n.status.fb[i] = 1'b1;
            end
        end

        // New events land after the clears above, so none is lost
        for (int i = 0; i < NCH; i++) begin
            if (!act[i]) begin
                n.pend_up[i] = 1'b0;
                n.pend_dn[i] = 1'b0;
            end else if (up_evt[i]) begin
                n.pend_up[i] = s.cfg[i].send_up;
                n.pend_dn[i] = 1'b0;
            end else if (dn_evt[i]) begin
                n.pend_dn[i] = s.cfg[i].send_dn;
                n.pend_up[i] = 1'b0;
            end
            if (!(cfgd[i] && s.cfg[i].fb_en && s.cfg[i].fb_active)) begin
                n.pend_fb[i] = 1'b0;
            end else if (changed[i] || init) begin
                n.pend_fb[i] = 1'b1;
            end
        end

        n.irq = |(n.status & n.mask);
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s          <= '0;
            s.ctrl     <= CTRL_RESET;
            s.cfg      <= {NCH{CFG_RESET}};
            s.lim_cfg  <= {NCH{LIMIT_DEF}};
            s.wait_req <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign readdata    = s.rdata;
    assign waitrequest = s.wait_req;
    assign irq         = s.irq;
    assign tel         = s.tel;
    assign fb          = s.fb;
endmodule
`default_nettype wire

/* common/limit_pkg.sv */
// Purpose: Shared types, offsets and helpers of the brightness limit monitor
// Assumes: 32-bit Avalon-MM words at byte addresses; brightness in whole lux
// Notes:   2-byte float objects use the 0.01 * M * 2^E layout
`default_nettype none
package limit_pkg;
    localparam int unsigned CLK_HZ    = 20_000_000;
    localparam int unsigned MS_PER_S  = 1000;
    localparam logic [15:0] MS_CYCLES = 16'(CLK_HZ / MS_PER_S);
    localparam int          NCH       = 3;

    // Global registers and per-channel pages (page 1..3 at bits 7:5)
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h04;
    localparam logic [7:0] MASK_OFS     = 8'h08;
    localparam logic [7:0] BRIGHT_OFS   = 8'h0C;
    localparam logic [7:0] FBDLY_OFS    = 8'h10;
    localparam logic [2:0] PAGE_GLOBAL  = 3'h0;
    localparam logic [2:0] PAGE_FIRST   = 3'h1;
    localparam logic [2:0] PAGE_LAST    = 3'h3;
    localparam logic [4:0] SUB_CFG      = 5'h00;
    localparam logic [4:0] SUB_LIMIT    = 5'h04;
    localparam logic [4:0] SUB_TEL      = 5'h08;
    localparam logic [4:0] SUB_PRESET   = 5'h0C;
    localparam logic [4:0] SUB_TEACH    = 5'h10;
    localparam logic [4:0] SUB_EFF      = 5'h14;
    localparam logic [4:0] SUB_THR      = 5'h18;

    localparam logic [15:0] LIMIT_MIN = 16'h000A;
    localparam logic [15:0] LIMIT_MAX = 16'h07D0;
    localparam logic [15:0] LIMIT_DEF = 16'h03E8;
    localparam logic [4:0]  HYST_MIN  = 5'h01;
    localparam logic [4:0]  HYST_MAX  = 5'h14;
    localparam logic [6:0]  PCT_FULL  = 7'h64;
    localparam logic [7:0]  DIM_MAX   = 8'h64;
    localparam logic [7:0]  SCENE_MAX = 8'h40;
    localparam logic [26:0] MANT_MAX  = 27'h00007FF;

    typedef enum logic [1:0] {TEACH_ON_ONE, TEACH_ON_ZERO, TEACH_ON_BOTH} teach_pol_t;
    typedef enum logic [1:0] {FMT_SWITCH, FMT_DIM, FMT_SCENE} fmt_t;
    typedef enum logic [1:0] {ZONE_UNKNOWN, ZONE_ABOVE, ZONE_BELOW} zone_t;

    typedef struct packed {
        logic       upper_type;
        logic [4:0] hyst;
        logic       overwrite;
        logic       preset_en;
        logic       teach_en;
        teach_pol_t teach_pol;
        logic       fb_en;
        logic       fb_active;
        fmt_t       fmt;
        logic       send_up;
        logic       send_dn;
    } ch_cfg_t;
    typedef struct packed {
        logic       eval_dis;
        logic [1:0] count;
        logic       enable;
    } ctrl_t;
    typedef struct packed {
        logic [NCH-1:0] fb;
        logic [NCH-1:0] dn;
        logic [NCH-1:0] up;
    } irq_t;
    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } thresh_t;
    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
        fmt_t       fmt;
        logic [7:0] data;
    } telegram_t;
    typedef struct packed {
        logic        valid;
        logic [1:0]  chan;
        logic [15:0] value;
    } feedback_t;

    localparam int      CFG_W      = $bits(ch_cfg_t);
    localparam int      CTRL_W     = $bits(ctrl_t);
    localparam int      IRQ_W      = $bits(irq_t);
    localparam ch_cfg_t CFG_RESET  = ch_cfg_t'(17'h15400);
    localparam ctrl_t   CTRL_RESET = ctrl_t'(4'h7);

    function automatic logic [15:0] clamp_limit(input logic [15:0] v);
        return (v < LIMIT_MIN) ? LIMIT_MIN : ((v > LIMIT_MAX) ? LIMIT_MAX : v);
    endfunction

    // Negative values have no meaning as a limit and fall to the minimum
    function automatic logic [15:0] f16_to_lux(input logic [15:0] f);
        logic [26:0] m;
        m = (27'(f[10:0]) << f[14:11]) / 27'(PCT_FULL);
        if (f[15]) return LIMIT_MIN;
        return clamp_limit((m > 27'(LIMIT_MAX)) ? LIMIT_MAX : m[15:0]);
    endfunction

    function automatic logic [15:0] lux_to_f16(input logic [15:0] lux);
        logic [26:0] m;
        logic [3:0]  e;
        m = 27'(lux) * 27'(PCT_FULL);
        e = '0;
        for (int k = 0; k < 15; k++) begin
            if (m > MANT_MAX) begin
                m = m >> 1;
                e = e + 4'h1;
            end
        end
        return {1'b0, e, m[10:0]};
    endfunction

    function automatic logic [7:0] tel_data(input fmt_t f, input logic [7:0] v);
        unique case (f)
            FMT_SWITCH: return {7'h00, v[0]};
            FMT_DIM:    return (v > DIM_MAX) ? DIM_MAX : v;
            FMT_SCENE:  return (v > SCENE_MAX) ? SCENE_MAX : v;
            default:    return '0;
        endcase
    endfunction
endpackage
`default_nettype wire

/* hdl/threshold_calc.sv */
// Purpose: Derives the upper and lower threshold of one channel
// Assumes: Limit already clamped to its legal range
// Notes:   One cycle of latency after a limit change
`timescale 1ns/1ps
`default_nettype none
module threshold_calc (
    input  wire logic           ref_clk,
    input  wire logic           rstn,
    input  wire logic [15:0]    limit,
    input  wire logic [4:0]     hyst,
    input  wire logic           upper_type,
    output var  limit_pkg::thresh_t thr
);
    import limit_pkg::*;

    thresh_t     s;
    thresh_t     n;
    logic [4:0]  pct;
    logic [20:0] prod;
    logic [15:0] h;

    // Hysteresis is relative to the current limit, so it follows every change
    always_comb begin
        pct  = (hyst < HYST_MIN) ? HYST_MIN : ((hyst > HYST_MAX) ? HYST_MAX : hyst);
        prod = 21'(limit) * 21'(pct);
        h    = 16'(prod / 21'(PCT_FULL));
        n    = s;
        if (upper_type) begin
            n.hi = limit;
            n.lo = limit - h;
        end else begin
            n.lo = limit;
            n.hi = limit + h;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign thr = s;
endmodule
`default_nettype wire

/* hdl/limit_channel.sv */
// Purpose: Limit value keeping and crossing detection of one channel
// Assumes: Pulses preset, teach, download and restart last one cycle
// Notes:   Zone starts unknown, so a fresh start reports the present side
`timescale 1ns/1ps
`default_nettype none
module limit_channel (
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire limit_pkg::ch_cfg_t  cfg,
    input  wire logic [15:0]         cfg_limit,
    input  wire logic [15:0]         bright,
    input  wire limit_pkg::thresh_t  thr,
    input  wire logic                preset,
    input  wire logic [15:0]         preset_val,
    input  wire logic                teach,
    input  wire logic                teach_val,
    input  wire logic                download,
    input  wire logic                restart,
    input  wire logic                eval_on,
    output logic [15:0]              limit,
    output logic                     up_evt,
    output logic                     dn_evt,
    output logic                     changed
);
    import limit_pkg::*;

    typedef struct packed {
        logic        ext;
        logic [15:0] ext_val;
        logic [15:0] limit;
        zone_t       zone;
        logic        up_evt;
        logic        dn_evt;
        logic        changed;
    } chan_state_t;

    chan_state_t s;
    chan_state_t n;

    // A later source in the same cycle wins: download, then preset, then teach
    always_comb begin
        n = s;
        n.up_evt = 1'b0;
        n.dn_evt = 1'b0;
        if (download && cfg.overwrite) n.ext = 1'b0;
        if (preset && cfg.preset_en) begin
            n.ext     = 1'b1;
            n.ext_val = f16_to_lux(preset_val);
        end
        if (teach && cfg.teach_en) begin
            unique case (cfg.teach_pol)
                TEACH_ON_ONE:  n.ext = teach_val;
                TEACH_ON_ZERO: n.ext = !teach_val;
                TEACH_ON_BOTH: n.ext = 1'b1;
                default:       n.ext = s.ext;
            endcase
            if (n.ext) n.ext_val = clamp_limit(bright);
        end
        n.limit   = n.ext ? n.ext_val : clamp_limit(cfg_limit);
        n.changed = n.limit != s.limit;
        // One report per crossing; the opposite side re-arms it
        if (!eval_on || restart) begin
            n.zone = ZONE_UNKNOWN;
        end else if (bright > thr.hi && s.zone != ZONE_ABOVE) begin
            n.zone   = ZONE_ABOVE;
            n.up_evt = 1'b1;
        end else if (bright < thr.lo && s.zone != ZONE_BELOW) begin
            n.zone   = ZONE_BELOW;
            n.dn_evt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s       <= '0;
            s.limit <= LIMIT_DEF;
        end else begin
            s <= n;
        end
    end

    assign limit   = s.limit;
    assign up_evt  = s.up_evt;
    assign dn_evt  = s.dn_evt;
    assign changed = s.changed;
endmodule
`default_nettype wire

/* testbench/bus_sink.sv */
// Purpose: Bus stand-in taking every telegram
// Assumes: valid flags are one-cycle pulses
// Notes:   Counts and keeps the last
`timescale 1ns/1ps
`default_nettype none
module bus_sink (
    input wire logic                 ref_clk,
    input wire limit_pkg::telegram_t tel,
    input wire limit_pkg::feedback_t fb
);
    import limit_pkg::*;
    int        n_tel = 0;
    int        n_fb = 0;
    telegram_t last_tel;
    feedback_t last_fb;
    // No back-pressure: one telegram per cycle
    always @(posedge ref_clk) begin
        if (tel.valid === 1'b1) begin
            n_tel <= n_tel + 1;
            last_tel <= tel;
        end
        if (fb.valid === 1'b1) begin
            n_fb <= n_fb + 1;
            last_fb <= fb;
        end
    end
endmodule
`default_nettype wire

/* testbench/limit_checker.sv */
// Purpose: Port checks of the limit monitor
// Assumes: Bound to the top, one clock
// Notes:   Telegram data checked for range
`timescale 1ns/1ps
`default_nettype none
module limit_checker (
    input wire logic                 ref_clk,
    input wire logic                 rstn,
    input wire logic                 read,
    input wire logic                 write,
    input wire logic                 waitrequest,
    input wire logic                 irq,
    input wire limit_pkg::telegram_t tel,
    input wire limit_pkg::feedback_t fb
);
    import limit_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // One answer, one cycle long
    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
    a_wait_pulse: assert property (!waitrequest |=> waitrequest) else $error("long answer");
    a_reset_quiet: assert property ($rose(rstn) |-> !irq && !tel.valid && !fb.valid && waitrequest)
        else $error("busy after reset");
    // Telegram ranges
    a_tel_once: assert property (tel.valid |=> !(tel.valid && tel.chan == $past(tel.chan)))
        else $error("repeated telegram");
    a_tel_chan: assert property (tel.valid |-> tel.chan != 2'h3) else $error("bad channel");
    a_tel_dim: assert property (tel.valid && tel.fmt == FMT_DIM |-> tel.data <= DIM_MAX)
        else $error("dim out of range");
    a_tel_scene: assert property (tel.valid && tel.fmt == FMT_SCENE |-> tel.data <= SCENE_MAX)
        else $error("scene out of range");
    a_fb_form: assert property (fb.valid |-> !fb.value[15] && fb.chan != 2'h3)
        else $error("bad feedback");
    // Irq drops only after a write
    a_irq_drop: assert property ($fell(irq) |-> $past(write) || $past(write, 2))
        else $error("irq dropped alone");
    cover property (tel.valid && tel.fmt == FMT_SCENE);
    cover property (fb.valid);
    cover property ($fell(irq));
endmodule
`default_nettype wire

/* testbench/brightness_limit_monitor_tb.sv */
// Purpose: Self-checking bench of the limit monitor
// Assumes: Pages at 0x20, 0x40, 0x60
// Notes:   Short ms tick
`timescale 1ns/1ps
`default_nettype none
module brightness_limit_monitor_tb;
    import limit_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  address = '0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = '0;
    logic        bus_return = 1'b0;
    logic        cfg_download = 1'b0;
    logic [31:0] readdata, rdata;
    logic        waitrequest, irq;
    telegram_t   tel;
    feedback_t   fb;
    int          miscompares = 0;
    int          checks = 0;
    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;
    brightness_limit_monitor #(.MS_TICK_CYCLES(16'h0004)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .bus_return(bus_return), .cfg_download(cfg_download), .irq(irq), .tel(tel), .fb(fb));
    bus_sink i_sink (.ref_clk(ref_clk), .tel(tel), .fb(fb));
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    // Held until waitrequest is seen low, then released
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (waitrequest !== 1'b0) begin
            miscompares++;
            close_out();
        end
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        acc(1'b0, a, 32'h0);
        check(what, exp, rdata);
    endtask
    // Write, then let it settle
    task automatic wrs(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic pulse(input logic br);
        bus_return <= br;
        cfg_download <= !br;
        @(posedge ref_clk);
        bus_return <= 1'b0;
        cfg_download <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
    // Hysteresis off or onto the limit, floored
    function automatic logic [31:0] thr(input logic up, input logic [4:0] h, input logic [15:0] l);
        logic [15:0] d;
        d = 16'((32'(l) * 32'(h)) / 32'h64);
        return up ? {l, l - d} : {l + d, l};
    endfunction
    function automatic logic [7:0] tdat(input logic [1:0] f, input logic [7:0] v);
        logic [7:0] m;
        m = (f == 2'h1) ? 8'h64 : 8'h40;
        return (f == 2'h0) ? {7'h00, v[0]} : ((v > m) ? m : v);
    endfunction
    initial begin
        logic [15:0] lim;
        logic [4:0]  h;
        logic [7:0]  uv, dv;
        int          nt, nf;
        void'($urandom(32'hDEF8));
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd(CTRL_OFS, 32'h7, "ctrl");
        rd(8'h20, 32'h15400, "cfg");
        rd(8'h34, 32'h3E8, "eff");
        rd(8'h38, 32'h03E80384, "thr");
        rd(8'h1C, 32'h0, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            h = (i == 0) ? HYST_MIN : (i == 1) ? HYST_MAX : 5'(32'h1 + $urandom % 32'h14);
            lim = (i == 0) ? LIMIT_MIN : (i == 1) ? LIMIT_MAX : 16'(32'hA + $urandom % 32'h7C7);
            acc(1'b1, 8'h40, {15'h0000, i[0], h, 11'h400});
            wrs(8'h44, 32'(lim));
            rd(8'h54, 32'(lim), "eff");
            rd(8'h58, thr(i[0], h, lim), "thr");
        end
        $display("test thresholds done");
        acc(1'b1, MASK_OFS, 32'h1);
        for (int f = 0; f < 3; f++) begin
            uv = 8'($urandom);
            dv = (f == 2) ? 8'h41 : 8'($urandom);
            acc(1'b1, 8'h20, 32'h15403 | (f << 2));
            acc(1'b1, 8'h28, {16'h0, dv, uv});
            wrs(BRIGHT_OFS, 32'h3B6);
            nt = i_sink.n_tel;
            wrs(BRIGHT_OFS, 32'h5DC);
            check("tel up", tdat(2'(f), uv), i_sink.last_tel.data);
            check("irq", 32'h1, 32'(irq));
            wrs(BRIGHT_OFS, 32'h640);
            check("tel count", nt + 1, i_sink.n_tel);
            wrs(BRIGHT_OFS, 32'h64);
            check("tel count", nt + 2, i_sink.n_tel);
            check("tel down", tdat(2'(f), dv), i_sink.last_tel.data);
            rd(STATUS_OFS, 32'h9, "status");
            wrs(STATUS_OFS, 32'h1FF);
            check("irq", 32'h0, 32'(irq));
        end
        $display("test crossing done");
        acc(1'b1, CTRL_OFS, 32'hF);
        wrs(8'h20, 32'h15733);
        nt = i_sink.n_tel;
        nf = i_sink.n_fb;
        wrs(BRIGHT_OFS, 32'h5DC);
        wrs(8'h2C, 32'h2E40);
        check("tel count", nt, i_sink.n_tel);
        rd(8'h34, 32'h200, "eff");
        rd(8'h38, 32'h020001CD, "thr");
        check("fb count", nf + 1, i_sink.n_fb);
        check("fb value", 32'h2E40, 32'(i_sink.last_fb.value));
        acc(1'b1, 8'h20, 32'h15333);
        pulse(1'b0);
        rd(8'h34, 32'h200, "eff");
        acc(1'b1, 8'h20, 32'h15733);
        pulse(1'b0);
        rd(8'h34, 32'h3E8, "eff");
        nf = i_sink.n_fb;
        pulse(1'b1);
        check("fb count", nf + 1, i_sink.n_fb);
        check("fb value", 32'h361A, 32'(i_sink.last_fb.value));
        wrs(8'h30, 32'h1);
        rd(8'h34, 32'h5DC, "eff");
        wrs(8'h30, 32'h0);
        rd(8'h34, 32'h3E8, "eff");
        acc(1'b1, 8'h20, 32'h157B3);
        wrs(8'h30, 32'h0);
        rd(8'h34, 32'h5DC, "eff");
        $display("test limits done");
        close_out();
    end
endmodule
bind brightness_limit_monitor limit_checker i_chk (
    .ref_clk(ref_clk), .rstn(rstn), .read(read), .write(write),
    .waitrequest(waitrequest), .irq(irq), .tel(tel), .fb(fb));
`default_nettype wire
